// [hw/fdc_cmd_pkg.sv]
// constants, types and behaviour list for the floppy seek/verify command block
//
// Behaviour
// R1 - relative seek: two command bytes, then count
// R2 - step count times; direction bit picks up/down
// R3 - track counter wider than eight bits
// R4 - verify takes two command bytes, seven parameters
// R5 - verify answers three status bytes, then CHRN
// R6 - verify reads sectors, checks CRC, sends nothing
// R7 - ID field errors set matching status bits
// R8 - data field errors set matching status bits
// R9 - after each sector, bump record, search again
// R10 - verify never stops early on error
// R11 - version query answers the version register
// R12 - hard reset loads version; soft keeps it
// R13 - version set stores byte, no answer
// R14 - lock answers lock flag in bit four
// R15 - lock shields fifo and precomp settings
// R16 - soft reset input; hard reset clears lock
// R17 - powerdown stores three bits, echoes them
// R18 - powerdown survives soft reset; drive reset clears
// R19 - FM, MFM, perpendicular 500K and 1M formats
// R20 - bits move most significant first
// R21 - sixteen bit CRC over marks and field
// R22 - missing-clock marks identify field types
// R23 - perpendicular 1M uses 41 byte gap two
package fdc_cmd_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_UNIT_US = 500;
  localparam int STEP_UNIT_CYC = STEP_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_RATE_SPAN = 5'h10;

  // ------------------------------------------------------------
  // command bytes and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OP_RSEEK_MASK = 8'hBF;
  localparam logic [7:0] OP_RSEEK = 8'h8F;
  localparam logic [7:0] OP_VERIFY_MASK = 8'h1F;
  localparam logic [7:0] OP_VERIFY = 8'h16;
  localparam logic [7:0] OP_VERSION = 8'h10;
  localparam logic [7:0] OP_VERSION_SET_COMMAND = 8'h30;
  localparam logic [7:0] OP_LOCK_MASK = 8'h7F;
  localparam logic [7:0] OP_LOCK = 8'h14;
  localparam logic [7:0] OP_PDOWN = 8'h17;
  localparam logic [7:0] RES_INVALID = 8'h80;
  localparam logic [3:0] NPAR_RSEEK = 4'h2;
  localparam logic [3:0] NPAR_VERIFY = 4'h8;
  localparam logic [3:0] NPAR_ONE = 4'h1;
  localparam int DIR_BIT = 6;
  localparam int MT_BIT = 7;
  localparam int MFM_BIT = 6;
  localparam int SK_BIT = 5;
  localparam int EC_BIT = 7;
  localparam int HEAD_BIT = 2;
  localparam int LOCK_CMD_BIT = 7;
  localparam int LOCK_RES_BIT = 4;
  localparam logic [7:0] CYL_WILDCARD = 8'hFF;

  // error flag positions inside the accumulated error vector
  localparam int E_IC0 = 0;
  localparam int E_NR = 1;
  localparam int E_EN = 2;
  localparam int E_DE = 3;
  localparam int E_ND = 4;
  localparam int E_MA = 5;
  localparam int E_CM = 6;
  localparam int E_DD = 7;
  localparam int E_MD = 8;

  // ------------------------------------------------------------
  // track format
  // ------------------------------------------------------------
  localparam logic [7:0] MARK_SYNC_MFM = 8'hA1;
  localparam logic [7:0] MARK_ID = 8'hFE;
  localparam logic [7:0] MARK_DATA = 8'hFB;
  localparam logic [7:0] MARK_DELETED = 8'hF8;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] ID_FIELD_BYTES = 16'h0006;
  localparam logic [15:0] CRC_BYTES = 16'h0002;
  localparam logic [15:0] SECTOR_BASE = 16'h0080;
  localparam logic [5:0] GAP2_NORMAL = 6'd22;
  localparam logic [5:0] GAP2_PERP1M = 6'd41;
  localparam logic [1:0] RATE_500K = 2'b00;
  localparam logic [1:0] RATE_1M = 2'b11;

  // ------------------------------------------------------------
  // values after hardware reset
  // ------------------------------------------------------------
  localparam logic DFI_RST = 1'b1;
  localparam logic [3:0] FTH_RST = 4'h0;
  localparam logic [7:0] PTN_RST = 8'h00;
  localparam logic [2:0] PD_RST = 3'h0;
  localparam logic LOCK_RST = 1'b0;

  typedef enum logic [1:0] {
    FMT_FM = 2'h0,
    FMT_MFM = 2'h1,
    FMT_PERP500 = 2'h2,
    FMT_PERP1M = 2'h3
  } fmt_t;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_CMD = 9'h002,
    S_EXEC = 9'h004,
    S_SEEK = 9'h008,
    S_IDSRCH = 9'h010,
    S_IDRD = 9'h020,
    S_DSRCH = 9'h040,
    S_DRD = 9'h080,
    S_RES = 9'h100
  } state_t;

endpackage

// [hw/crc16_msb_first.sv]
// sixteen bit field CRC, one byte per cycle, most significant bit first
module crc16_msb_first (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte stream
  input wire logic start,
  input wire logic feed,
  input wire logic [7:0] dataIn,
  // check value
  output logic [15:0] crcNext
);
  import fdc_cmd_pkg::*;

  logic [15:0] crcR;
  logic [15:0] chain [0:8];

  // start reseeds so the first mark byte is already covered
  assign chain[0] = start ? CRC_INIT : crcR;

  // one stage per data bit, D7 enters first
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign chain[i+1] = {chain[i][14:0], 1'b0} ^
      ((chain[i][15] ^ dataIn[7-i]) ? CRC_POLY : 16'h0000); // R20 R21
  end

  assign crcNext = chain[8];

  // register only advances on a fed byte
  always_ff @(posedge clk) begin
    if (rst) begin
      crcR <= CRC_INIT;
    end else if (feed) begin
      crcR <= crcNext;
    end
  end

endmodule // crc16_msb_first

// [hw/fdc_seek_verify.sv]
// command interpreter for relative seek, verify, version, lock and powerdown
module fdc_seek_verify #(
  parameter int TRACK_W = 10,
  parameter int STEP_UNIT = fdc_cmd_pkg::STEP_UNIT_CYC,
  parameter logic [7:0] VERSION_ID = 8'h5A // arbitrary identity value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host byte port
  input wire logic [7:0] hostByte,
  input wire logic hostWrite,
  output logic hostReady,
  output logic [7:0] resultByte,
  output logic resultValid,
  input wire logic hostRead,
  output logic cmdBusy,
  // resets and settings from the rest of the controller
  input wire logic softReset,
  input wire logic resetDrive,
  input wire logic cfgLoad,
  input wire logic cfgFifoDisable,
  input wire logic [3:0] cfgThreshold,
  input wire logic [7:0] cfgPrecompTrack,
  input wire logic [3:0] stepRateCode,
  input wire logic perpEnable,
  input wire logic [1:0] dataRate,
  // held settings
  output logic lockFlag,
  output logic fifoDisable,
  output logic [3:0] fifoThreshold,
  output logic [7:0] precompStartTrack,
  output logic featureBit,
  output logic minimumDelayBit,
  output logic autoPowerdownBit,
  output fdc_cmd_pkg::fmt_t trackFormat,
  output logic [5:0] gap2Length,
  // drive side
  input wire logic driveReady,
  input wire logic trackZero,
  input wire logic indexPulse,
  input wire logic [7:0] rdByte,
  input wire logic rdValid,
  input wire logic rdMark,
  output logic stepPulse,
  output logic stepDir,
  output logic [1:0] driveSelect,
  output logic headSelect,
  output logic seekDone,
  output logic [TRACK_W-1:0] currentTrack
);
  import fdc_cmd_pkg::*;

  // --------------------
  // declarations
  // --------------------
  state_t stateR, stateNxt;
  logic [7:0] cmdR;
  logic [7:0] parR [0:7];
  logic [3:0] parIdx;
  logic [7:0] verR;
  logic [2:0] pdR;
  logic mtR, mfmR, skR, ecR, dirR, curHeadR;
  logic [1:0] unitR;
  logic [7:0] stepsR, cylR, hdR, recR, sizeR, eotR, dtlR, doneCnt;
  logic [8:0] errR, errSet, errNxt;
  logic [15:0] unitCnt, byteCnt;
  logic [4:0] periodCnt;
  logic [7:0] pulseCnt;
  logic [1:0] idxR;
  logic idSeenR, syncR, mismR, seekDoneR;
  logic [7:0] resBuf [0:6];
  logic [7:0] resIn [0:6];
  logic [2:0] resCnt;
  logic [TRACK_W-1:0] trackR [0:3];
  logic [15:0] crcNext;
  fmt_t fmtR;
  logic [5:0] gapR;

  // --------------------
  // command decode
  // --------------------
  // first byte is decoded straight off the bus, later from the latch
  wire [7:0] decByte = (stateR == S_IDLE) ? hostByte : cmdR;
  wire isRel = (decByte & OP_RSEEK_MASK) == OP_RSEEK; // R1
  wire isVerify = (decByte & OP_VERIFY_MASK) == OP_VERIFY; // R4
  wire isVersion = decByte == OP_VERSION; // R11
  wire isVerset = decByte == OP_VERSION_SET_COMMAND; // R13
  wire isLock = (decByte & OP_LOCK_MASK) == OP_LOCK;
  wire isPdown = decByte == OP_PDOWN; // R17
  wire [3:0] needCnt = isRel ? NPAR_RSEEK : isVerify ? NPAR_VERIFY :
    (isVerset || isPdown) ? NPAR_ONE : 4'h0;

  wire inExec = stateR == S_EXEC;
  wire execRel = inExec && isRel;
  wire execVerify = inExec && isVerify;
  wire execLock = inExec && isLock;
  wire execPd = inExec && isPdown;

  // --------------------
  // step timing
  // --------------------
  // half-millisecond tick; step period is sixteen minus the rate code
  wire unitTick = unitCnt == 16'(STEP_UNIT - 1);
  wire [4:0] stepPeriod = STEP_RATE_SPAN - {1'b0, stepRateCode};
  wire periodDone = unitTick && (periodCnt == stepPeriod - 5'h01);
  wire blockedOut = !dirR && trackZero;
  wire stepFire = (stateR == S_SEEK) && periodDone && stepsR != 8'h00 &&
    driveReady && !blockedOut; // R2
  // one quiet period after the last step before the seek ends
  wire seekEnd = (stateR == S_SEEK) && periodDone && !stepFire;

  // --------------------
  // track stream decode
  // --------------------
  wire fm = !mfmR;
  wire inSearch = stateR == S_IDSRCH || stateR == S_DSRCH;
  wire inRead = stateR == S_IDRD || stateR == S_DRD;
  // FM marks are single missing-clock bytes, MFM marks follow A1 syncs
  wire crcStart = inSearch && rdValid && rdMark && !syncR &&
    (fm || rdByte == MARK_SYNC_MFM); // R22
  wire typeValid = inSearch && rdValid &&
    (fm ? rdMark : (syncR && !rdMark)); // R22
  wire crcFeed = rdValid && (crcStart || (inSearch && syncR) || inRead); // R21
  wire isIdType = typeValid && rdByte == MARK_ID;
  wire isDataType = typeValid && rdByte == MARK_DATA;
  wire isDelType = typeValid && rdByte == MARK_DELETED;

  // --------------------
  // field lengths and ID compare
  // --------------------
  wire [15:0] sectorBytes = (sizeR == 8'h00) ? {8'h00, dtlR} :
    (SECTOR_BASE << sizeR[2:0]);
  wire [15:0] fieldLen = (stateR == S_IDRD) ? ID_FIELD_BYTES : sectorBytes + CRC_BYTES;
  wire lastByte = inRead && rdValid && byteCnt == fieldLen - 16'h0001;
  wire [7:0] wantByte = (byteCnt[1:0] == 2'h0) ? cylR :
    (byteCnt[1:0] == 2'h1) ? hdR : (byteCnt[1:0] == 2'h2) ? recR : sizeR;
  wire cylWild = byteCnt[1:0] == 2'h0 && cylR == CYL_WILDCARD; // R7
  wire mismNow = (stateR == S_IDRD) && rdValid && byteCnt < 16'h0004 &&
    !cylWild && rdByte != wantByte;
  wire crcBad = crcNext != 16'h0000;
  wire idGood = !crcBad && !mismR && !mismNow;

  // --------------------
  // sector outcome
  // --------------------
  wire idMiss = (stateR == S_IDSRCH) && indexPulse && idxR == 2'h1;
  wire dataMiss = (stateR == S_DSRCH) &&
    ((typeValid && !isDataType && !isDelType) || indexPulse);
  wire skipDel = (stateR == S_DSRCH) && isDelType && skR;
  wire dataStart = (stateR == S_DSRCH) && (isDataType || (isDelType && !skR));
  wire dataDone = (stateR == S_DRD) && lastByte;
  // every sector closes through here, good or bad
  wire sectorEnd = idMiss || dataMiss || skipDel || dataDone; // R10
  wire lastRec = recR == eotR;
  wire headSwap = mtR && !curHeadR;
  wire countHit = doneCnt + 8'h01 == dtlR;
  wire trackEnd = lastRec && !headSwap;
  wire finishNow = ecR ? (countHit || trackEnd) : trackEnd;
  wire incomplete = ecR && trackEnd && !countHit;
  wire verifyDone = sectorEnd && finishNow;

  // --------------------
  // error accumulation
  // --------------------
  // flags pile up over one verify and are cleared as it starts; which sector failed is not kept
  always_comb begin
    errSet = 9'h000;
    errSet[E_IC0] = (execVerify && !driveReady) || (idMiss && !idSeenR) ||
      dataMiss || (sectorEnd && incomplete && finishNow); // R7 R8
    errSet[E_NR] = execVerify && !driveReady; // R7
    errSet[E_MA] = (idMiss && !idSeenR) || dataMiss; // R7 R8
    errSet[E_ND] = idMiss && idSeenR; // R7
    errSet[E_DE] = inRead && lastByte && crcBad; // R6 R7 R8
    errSet[E_DD] = dataDone && crcBad; // R8
    errSet[E_MD] = dataMiss; // R8
    errSet[E_CM] = isDelType && (stateR == S_DSRCH); // R8
    errSet[E_EN] = sectorEnd && incomplete && finishNow; // R8
  end

  assign errNxt = execVerify ? errSet : (errR | errSet);

  // --------------------
  // state machine
  // --------------------
  always_comb begin
    stateNxt = stateR;
    case (stateR)
      S_IDLE: if (hostWrite) stateNxt = (needCnt == 4'h0) ? S_EXEC : S_CMD;
      S_CMD: if (hostWrite && parIdx == needCnt - 4'h1) stateNxt = S_EXEC;
      S_EXEC: begin
        if (isRel) stateNxt = S_SEEK;
        else if (isVerify) stateNxt = driveReady ? S_IDSRCH : S_RES;
        else if (isVerset) stateNxt = S_IDLE; // R13
        else stateNxt = S_RES;
      end
      S_SEEK: if (seekEnd) stateNxt = S_IDLE;
      S_IDSRCH: begin
        if (verifyDone) stateNxt = S_RES;
        else if (isIdType) stateNxt = S_IDRD;
      end
      S_IDRD: if (lastByte) stateNxt = idGood ? S_DSRCH : S_IDSRCH;
      S_DSRCH: begin
        if (verifyDone) stateNxt = S_RES;
        else if (dataStart) stateNxt = S_DRD;
        else if (sectorEnd) stateNxt = S_IDSRCH;
      end
      S_DRD: begin
        if (verifyDone) stateNxt = S_RES;
        else if (lastByte) stateNxt = S_IDSRCH; // R9
      end
      S_RES: if (hostRead && resCnt == 3'h1) stateNxt = S_IDLE;
      default: stateNxt = S_IDLE;
    endcase
    if (softReset) stateNxt = S_IDLE;
  end

  always_ff @(posedge clk) begin
    if (rst) stateR <= S_IDLE;
    else stateR <= stateNxt;
  end

  // command and parameter capture
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdR <= 8'h00;
      parIdx <= 4'h0;
    end else if (stateR == S_IDLE && hostWrite) begin
      cmdR <= hostByte;
      parIdx <= 4'h0;
    end else if (stateR == S_CMD && hostWrite) begin
      parIdx <= parIdx + 4'h1;
    end
  end

  for (genvar p = 0; p < 8; p++) begin : g_par
    always_ff @(posedge clk) begin
      if (rst) parR[p] <= 8'h00;
      else if (stateR == S_CMD && hostWrite && parIdx == 4'(p)) parR[p] <= hostByte;
    end
  end

  // --------------------
  // seek and step pulse
  // --------------------
  always_ff @(posedge clk) begin
    if (rst || unitTick) unitCnt <= 16'h0000;
    else unitCnt <= unitCnt + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (rst || stateR != S_SEEK || periodDone) periodCnt <= 5'h00;
    else if (unitTick) periodCnt <= periodCnt + 5'h01;
  end

  // pulse width is stretched so the drive sees a clean edge
  always_ff @(posedge clk) begin
    if (rst) pulseCnt <= 8'h00;
    else if (stepFire) pulseCnt <= 8'(STEP_PULSE_CYC);
    else if (pulseCnt != 8'h00) pulseCnt <= pulseCnt - 8'h01;
  end

  // relative count, so the head can pass track 255
  for (genvar d = 0; d < 4; d++) begin : g_track
    always_ff @(posedge clk) begin
      if (rst) begin
        trackR[d] <= '0;
      end else if (stepFire && unitR == 2'(d)) begin
        if (dirR) trackR[d] <= trackR[d] + 1'b1; // R2 R3
        else if (trackR[d] != '0) trackR[d] <= trackR[d] - 1'b1; // R2
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dirR <= 1'b0;
      stepsR <= 8'h00;
      seekDoneR <= 1'b0;
      currentTrack <= '0;
    end else begin
      seekDoneR <= seekEnd;
      currentTrack <= trackR[unitR];
      if (execRel) begin
        dirR <= cmdR[DIR_BIT]; // R1 R2
        stepsR <= parR[1]; // R1
      end else if (stepFire) begin
        stepsR <= stepsR - 8'h01; // R2
      end
    end
  end

  // --------------------
  // verify sector walk
  // --------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      {mtR, mfmR, skR, ecR, curHeadR, unitR} <= 7'h20; // MFM until told otherwise
      {cylR, hdR, recR, sizeR, eotR, dtlR, doneCnt} <= 56'h0;
      errR <= 9'h000;
    end else begin
      errR <= errNxt;
      if (execRel) unitR <= parR[0][1:0];
      if (execVerify) begin
        mtR <= cmdR[MT_BIT];
        mfmR <= cmdR[MFM_BIT];
        skR <= cmdR[SK_BIT];
        ecR <= parR[0][EC_BIT];
        curHeadR <= parR[0][HEAD_BIT];
        unitR <= parR[0][1:0];
        {cylR, hdR, recR, sizeR, eotR} <= {parR[1], parR[2], parR[3], parR[4], parR[5]};
        dtlR <= parR[7];
        doneCnt <= 8'h00;
      end else if (sectorEnd && !finishNow) begin
        doneCnt <= doneCnt + 8'h01;
        if (lastRec) begin
          curHeadR <= 1'b1;
          hdR <= 8'h01;
          recR <= 8'h01;
        end else begin
          recR <= recR + 8'h01; // R9
        end
      end
    end
  end

  // search bookkeeping: revolutions, sync, byte count, ID compare
  always_ff @(posedge clk) begin
    if (rst || execVerify || sectorEnd) begin
      idxR <= 2'h0;
      idSeenR <= 1'b0;
    end else begin
      if (inSearch && indexPulse && idxR != 2'h2) idxR <= idxR + 2'h1;
      if (isIdType) idSeenR <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !inSearch || typeValid) syncR <= 1'b0;
    else if (crcStart && !fm) syncR <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst || !inRead || lastByte) byteCnt <= 16'h0000;
    else if (rdValid) byteCnt <= byteCnt + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (rst || stateR != S_IDRD) mismR <= 1'b0;
    else if (mismNow) mismR <= 1'b1;
  end

  // residue of zero after the stored CRC means the field is good
  crc16_msb_first u_crc (
    .clk(clk),
    .rst(rst),
    .start(crcStart),
    .feed(crcFeed),
    .dataIn(rdByte),
    .crcNext(crcNext)
  );

  // --------------------
  // settings registers
  // --------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      verR <= VERSION_ID; // R12
      lockFlag <= LOCK_RST; // R16
      pdR <= PD_RST; // R18
    end else begin
      if (inExec && isVerset) verR <= parR[0]; // R13
      if (execLock) lockFlag <= cmdR[LOCK_CMD_BIT]; // R14
      if (resetDrive) pdR <= PD_RST; // R18
      else if (execPd) pdR <= parR[0][2:0]; // R17
    end
  end

  // soft reset only reaches these while unlocked
  always_ff @(posedge clk) begin
    if (rst || (softReset && !lockFlag)) begin // R15 R16
      fifoDisable <= DFI_RST;
      fifoThreshold <= FTH_RST;
      precompStartTrack <= PTN_RST;
    end else if (cfgLoad) begin
      fifoDisable <= cfgFifoDisable;
      fifoThreshold <= cfgThreshold;
      precompStartTrack <= cfgPrecompTrack;
    end
  end

  // perpendicular formats only once enabled, and only at 500K or 1M
  always_ff @(posedge clk) begin
    if (rst) begin
      fmtR <= FMT_MFM;
      gapR <= GAP2_NORMAL;
    end else begin
      if (!mfmR) fmtR <= FMT_FM; // R19
      else if (perpEnable && dataRate == RATE_1M) fmtR <= FMT_PERP1M; // R19
      else if (perpEnable && dataRate == RATE_500K) fmtR <= FMT_PERP500;
      else fmtR <= FMT_MFM;
      gapR <= (mfmR && perpEnable && dataRate == RATE_1M) ? GAP2_PERP1M : GAP2_NORMAL; // R23
    end
  end

  // --------------------
  // result buffer
  // --------------------
  wire [7:0] oneByte = isVersion ? verR : // R11
    isLock ? 8'(cmdR[LOCK_CMD_BIT]) << LOCK_RES_BIT : // R14
    isPdown ? {5'h00, parR[0][2:0]} : RES_INVALID; // R17
  wire loadRes = (inExec && !isRel && !isVerset && !(isVerify && driveReady)) ||
    verifyDone;

  // a not-ready verify answers in the execute cycle, before the walk registers load
  wire headRes = inExec ? parR[0][HEAD_BIT] : curHeadR;
  wire [1:0] unitRes = inExec ? parR[0][1:0] : unitR;

  // status bytes first, then cylinder, head, record, size
  assign resIn[0] = isVerify ? {1'b0, errNxt[E_IC0], 2'h0, errNxt[E_NR], headRes, unitRes}
    : oneByte; // R5
  assign resIn[1] = {errNxt[E_EN], 1'b0, errNxt[E_DE], 2'h0, errNxt[E_ND], 1'b0,
    errNxt[E_MA]}; // R5
  assign resIn[2] = {1'b0, errNxt[E_CM], errNxt[E_DD], 4'h0, errNxt[E_MD]}; // R5
  assign resIn[3] = inExec ? parR[1] : cylR;
  assign resIn[4] = inExec ? parR[2] : hdR;
  assign resIn[5] = inExec ? parR[3] : recR;
  assign resIn[6] = inExec ? parR[4] : sizeR;

  for (genvar r = 0; r < 7; r++) begin : g_res
    always_ff @(posedge clk) begin
      if (rst) resBuf[r] <= 8'h00;
      else if (loadRes) resBuf[r] <= resIn[r];
      else if (stateR == S_RES && hostRead) resBuf[r] <= (r == 6) ? 8'h00 : resBuf[(r+1)%7];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) resCnt <= 3'h0;
    else if (loadRes) resCnt <= isVerify ? 3'h7 : 3'h1;
    else if (stateR == S_RES && hostRead) resCnt <= resCnt - 3'h1;
  end

  // --------------------
  // outputs
  // --------------------
  assign hostReady = stateR == S_IDLE || stateR == S_CMD;
  assign resultValid = stateR == S_RES;
  assign cmdBusy = stateR != S_IDLE;
  assign resultByte = resBuf[0];
  assign featureBit = pdR[2];
  assign minimumDelayBit = pdR[1];
  assign autoPowerdownBit = pdR[0];
  assign trackFormat = fmtR;
  assign gap2Length = gapR;
  assign stepPulse = pulseCnt != 8'h00;
  assign stepDir = dirR;
  assign driveSelect = unitR;
  assign headSelect = curHeadR;
  assign seekDone = seekDoneR;

endmodule // fdc_seek_verify

// [sim/drive_model.sv]
// floppy drive stand-in: ready level, track zero, index pulses, idle read line
module drive_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready,
  input wire logic [9:0] currentTrack,
  output logic driveReady,
  output logic trackZero,
  output logic indexPulse,
  output logic [7:0] rdByte,
  output logic rdValid,
  output logic rdMark
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] turn_r;
  // one revolution every 64 cycles, short so missing-mark searches end fast
  always_ff @(posedge clk) turn_r <= rst ? 6'h0 : turn_r + 6'h1;
  assign driveReady = ready;
  assign trackZero = (currentTrack == 10'h0);
  assign indexPulse = (turn_r == 6'h3F);
  // no sector passes the head, so the idle data line keeps changing
  assign rdByte = {2'h0, turn_r} ^ 8'hA5;
  assign rdValid = 1'b0;
  assign rdMark = 1'b0;
endmodule // drive_model

// [sim/fdc_seek_verify_checker.sv]
// port assertions for the seek/verify command block
module fdc_seek_verify_checker import fdc_cmd_pkg::*; (
  input wire logic clk, rst, hostWrite, hostReady, cmdBusy, resultValid, softReset,
  input wire logic resetDrive, cfgLoad, lockFlag, fifoDisable, featureBit,
  input wire logic minimumDelayBit, autoPowerdownBit, perpEnable, stepPulse,
  input wire logic [7:0] hostByte, resultByte,
  input wire fmt_t trackFormat,
  input wire logic [5:0] gap2Length
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire idleTake = hostWrite && hostReady && !cmdBusy && !softReset;
  sequence stepBody;
    stepPulse [*8] ##12 stepPulse ##1 !stepPulse;
  endsequence
  a_version_answer:
    assert property (idleTake && hostByte == OP_VERSION |-> ##2 resultValid) else $error("late");
  a_lock_bit_four:
    assert property (idleTake && (hostByte & OP_LOCK_MASK) == OP_LOCK |-> ##2 resultValid
      && resultByte == {3'h0, $past(hostByte[7], 2), 4'h0}) else $error("lock byte");
  a_powerdown_held:
    assert property (resetDrive ##1 resetDrive |-> !featureBit && !minimumDelayBit
      && !autoPowerdownBit) else $error("powerdown bits");
  a_locked_keep:
    assert property (softReset && lockFlag && !cfgLoad |=> $stable(fifoDisable)) else $error("fifo");
  a_soft_lock:
    assert property (softReset && !cmdBusy |=> lockFlag == $past(lockFlag)) else $error("lock");
  a_soft_abort:
    assert property (softReset |=> !cmdBusy) else $error("abort");
  a_step_width:
    assert property ($rose(stepPulse) |-> stepBody) else $error("step width");
  a_gap_length:
    assert property (gap2Length == (trackFormat == FMT_PERP1M ? GAP2_PERP1M : GAP2_NORMAL))
      else $error("gap two");
  a_format_default:
    assert property (!perpEnable |=> trackFormat inside {FMT_FM, FMT_MFM}) else $error("fmt");
endmodule // fdc_seek_verify_checker
bind fdc_seek_verify fdc_seek_verify_checker checker_u (.*);

// [sim/tb.sv]
// self-checking bench for the seek/verify command block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fdc_cmd_pkg::*;
  localparam logic [7:0] VID = 8'hC3; // arbitrary identity value
  logic clk = 0, rst = 1, hostWrite = 0, hostRead = 0, softReset = 0, resetDrive = 0;
  logic cfgLoad = 0, cfgFifoDisable = 0, perpEnable = 0, ready = 1;
  logic [7:0] hostByte = 8'h00;
  logic [1:0] dataRate = 2'h0;
  logic hostReady, resultValid, cmdBusy, lockFlag, fifoDisable, featureBit, minimumDelayBit;
  logic autoPowerdownBit, stepPulse, stepDir, headSelect, seekDone, driveReady, trackZero;
  logic indexPulse, rdValid, rdMark;
  logic [7:0] resultByte, rdByte;
  logic [9:0] currentTrack;
  logic [5:0] gap2Length;
  fmt_t trackFormat;
  int error_cnt = 0, compares = 0, cycles = 0;
  logic [7:0] vp [7] = '{8'h01, 8'h00, 8'h01, 8'h02, 8'h01, 8'h1B, 8'hFF};
  always #25 clk = ~clk;
  fdc_seek_verify #(.STEP_UNIT(10), .VERSION_ID(VID)) dut_u (.*, .cfgThreshold(4'h3),
    .cfgPrecompTrack(8'h20), .stepRateCode(4'h0), .fifoThreshold(), .precompStartTrack(),
    .driveSelect());
  drive_model model_u (.*);
  task end_of_test;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] b);
    @(posedge clk) hostByte <= b;
    hostWrite <= 1;
    @(posedge clk) hostWrite <= 0;
  endtask
  // judged at the falling edge, clear of the edge that pops it
  task rd(input logic [7:0] exp);
    do @(negedge clk); while (resultValid !== 1'b1);
    chk(resultByte, exp);
    @(posedge clk) hostRead <= 1;
    @(posedge clk) hostRead <= 0;
  endtask
  task pulse_soft;
    @(posedge clk) softReset <= 1;
    @(posedge clk) softReset <= 0;
    @(negedge clk);
  endtask
  task seek(input logic [7:0] cmd, input logic [7:0] n, input logic [7:0] exp);
    wr(cmd);
    wr(8'h00);
    wr(n);
    do @(negedge clk); while (seekDone !== 1'b1);
    repeat (2) @(negedge clk);
    chk(currentTrack[7:0], exp);
    chk({7'h0, stepDir}, {7'h0, cmd[DIR_BIT]});
  endtask
  task verify(input logic rdy, input logic [7:0] st0, input logic [7:0] st1);
    @(posedge clk) ready <= rdy;
    wr(8'h56);
    wr(8'h00);
    foreach (vp[i]) wr(vp[i]);
    rd(st0);
    rd(st1);
    rd(8'h00);
    for (int i = 0; i < 4; i++) rd(vp[i]);
  endtask
  task t_version;
    wr(OP_VERSION);
    rd(VID);
    wr(OP_VERSION_SET_COMMAND);
    wr(8'h3C);
    repeat (4) @(negedge clk);
    chk({7'h0, resultValid}, 8'h00);
    pulse_soft();
    wr(OP_VERSION);
    rd(8'h3C);
  endtask
  task t_lock;
    wr(8'h94);
    rd(8'h10);
    @(posedge clk) cfgLoad <= 1;
    @(posedge clk) cfgLoad <= 0;
    pulse_soft();
    chk({7'h0, fifoDisable}, 8'h00);
    wr(OP_LOCK);
    rd(8'h00);
    pulse_soft();
    chk({7'h0, fifoDisable}, 8'h01);
  endtask
  task t_powerdown;
    wr(OP_PDOWN);
    wr(8'h05);
    rd(8'h05);
    pulse_soft();
    chk({5'h0, featureBit, minimumDelayBit, autoPowerdownBit}, 8'h05);
    @(posedge clk) resetDrive <= 1;
    repeat (3) @(negedge clk);
    chk({5'h0, featureBit, minimumDelayBit, autoPowerdownBit}, 8'h00);
    @(posedge clk) resetDrive <= 0;
  endtask
  task t_format;
    @(posedge clk) dataRate <= 2'h3;
    perpEnable <= 1;
    repeat (3) @(negedge clk);
    chk({6'h0, trackFormat}, {6'h0, FMT_PERP1M});
    chk({2'h0, gap2Length}, 8'h29);
    @(posedge clk) perpEnable <= 0;
    repeat (3) @(negedge clk);
    chk({6'h0, trackFormat}, {6'h0, FMT_MFM});
  endtask
  task t_hard;
    wr(8'h94);
    rd(8'h10);
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk({7'h0, lockFlag}, 8'h00);
    wr(OP_VERSION);
    rd(VID);
    chk({6'h0, trackFormat}, {6'h0, FMT_MFM});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_version();
    t_lock();
    t_powerdown();
    seek(8'hCF, 8'h03, 8'h03);
    seek(8'h8F, 8'h02, 8'h01);
    verify(1'b0, 8'h48, 8'h00);
    verify(1'b1, 8'h40, 8'h01);
    t_format();
    t_hard();
    end_of_test();
  end
  // ceiling well past what the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
endmodule // tb
